// >>> common/msd_pkg.sv
/*
  Shared constants and types for the memory map decoder and the low
  special function register bank.
  Assumes a 20-bit core address and a 32-bit Avalon-MM register bus.
*/
`default_nettype none

package msd_pkg;

  // Core address and bus geometry
  localparam int ADDR_W = 20;
  localparam int BUS_AW = 12;
  localparam int SFR_N = 48;

  // Region bounds
  localparam logic [19:0] SFR_HI = 20'h002ff;
  localparam logic [19:0] RAM_LO = 20'h00400;
  localparam logic [19:0] ROM_HI = 20'h0ffff;
  localparam logic [19:0] ROM_TOP = 20'h10000;
  localparam logic [19:0] VEC_LO = 20'h0ffdc;
  localparam logic [19:0] VEC_HI = 20'h0ffff;

  // Register indices, byte address is four times the index
  localparam logic [5:0] OFF_PROC_MODE_0 = 6'h04;
  localparam logic [5:0] OFF_PROC_MODE_1 = 6'h05;
  localparam logic [5:0] OFF_CLK_CTRL_0 = 6'h06;
  localparam logic [5:0] OFF_CLK_CTRL_1 = 6'h07;
  localparam logic [5:0] OFF_WRITE_PROTECT = 6'h0a;
  localparam logic [5:0] OFF_OSC_STOP = 6'h0c;
  localparam logic [5:0] OFF_WDOG_REFRESH = 6'h0d;
  localparam logic [5:0] OFF_WDOG_BEGIN = 6'h0e;
  localparam logic [5:0] OFF_WDOG_CONTROL = 6'h0f;
  localparam logic [5:0] OFF_MATCH_0 = 6'h10;
  localparam logic [5:0] OFF_MATCH_ENABLE = 6'h13;
  localparam logic [5:0] OFF_MATCH_1 = 6'h14;
  localparam logic [5:0] OFF_COUNT_SRC = 6'h1c;
  localparam logic [5:0] OFF_HS_OSC_0 = 6'h23;
  localparam logic [5:0] OFF_HS_OSC_1 = 6'h24;
  localparam logic [5:0] OFF_HS_OSC_2 = 6'h25;
  localparam logic [5:0] OFF_PRESCALE_FLAG = 6'h28;
  localparam logic [5:0] OFF_HS_OSC_4 = 6'h29;
  localparam logic [5:0] OFF_HS_OSC_6 = 6'h2b;
  localparam logic [5:0] OFF_HS_OSC_7 = 6'h2c;
  localparam logic [5:0] OFF_STATUS = 6'h2e;

  // Reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_CLK_CTRL_0 = 8'h68;
  localparam logic [7:0] RST_CLK_CTRL_1 = 8'h20;
  localparam logic [7:0] RST_OSC_STOP = 8'h04;
  localparam logic [7:0] RST_WDOG_CONTROL = 8'h1f;
  localparam logic [7:0] WDOG_DEFINED = 8'hdf;

  // Address match enable bits
  localparam int MATCH_EN_0 = 0;
  localparam int MATCH_EN_1 = 1;

  // Decoded region of a core address
  typedef enum logic [1:0] {RGN_SFR, RGN_RAM, RGN_ROM, RGN_RSVD}
    msd_region_t;

  // Decode result
  typedef struct packed {
    msd_region_t region;
    logic inVector;
    logic sfrMapped;
  } msd_decode_t;

  // Register values driven to the rest of the chip
  typedef struct packed {
    logic [7:0] procMode0;
    logic [7:0] procMode1;
    logic [7:0] clkCtrl0;
    logic [7:0] clkCtrl1;
    logic [7:0] writeProtect;
    logic [7:0] oscStopDetect;
    logic [7:0] wdogControl;
    logic [7:0] countSrcProtect;
    logic [7:0] prescalerReset;
    logic [7:0] hsOsc0;
    logic [7:0] hsOsc1;
    logic [7:0] hsOsc2;
    logic [7:0] hsOsc4;
    logic [7:0] hsOsc6;
    logic [7:0] hsOsc7;
  } msd_ctrl_t;

endpackage

`default_nettype wire

// >>> design/msd_sfr_decoder.sv
/*
  Memory map decoder and low special function register bank.
  Assumes one clock, an Avalon-MM master on the register side and
  core address logic on the same clock on the decode side.
*/
// The Avalon-MM slave port was left to the implementer.
// Contract
// - One megabyte space, each address one region
// - ROM ends at top, base follows size
// - RAM rises from fixed base by size
// - Vector table in topmost ROM locations
// - Lowest block goes to register bank
// - Processor mode registers reset to zero
// - Clock control registers reset to constants
// - Oscillation stop detect resets to 04h
// - Watchdog control resets 00X11111, others undefined
// - Address match registers placed, reset zero
// - Count source protection resets to zero
// - Prescaler reset flag clears on reset
// - Oscillator trims load factory values
`timescale 1ns/100ps
`default_nettype none

module msd_sfr_decoder
  import msd_pkg::*;
#(
  parameter int ROM_KBYTES = 32,
  parameter int RAM_BYTES = 1536,
  // Factory trim defaults; values arbitrary
  parameter logic [7:0] TRIM_1 = 8'h80,
  parameter logic [7:0] TRIM_4 = 8'h80,
  parameter logic [7:0] TRIM_6 = 8'h80,
  parameter logic [7:0] TRIM_7 = 8'h80
)
(
  input wire logic clock, // System clock
  input wire logic rstn, // Async reset, low
  input wire logic [BUS_AW-1:0] address, // Avalon byte address
  input wire logic read, // Avalon read
  input wire logic write, // Avalon write
  input wire logic [31:0] writedata, // Avalon write data
  input wire logic [3:0] byteenable, // Avalon lanes
  output logic [31:0] readdata, // Avalon read data
  output logic waitrequest, // Avalon stall
  input wire logic [ADDR_W-1:0] cpuAddr, // Core address
  input wire logic cpuValid, // Core address valid
  output msd_decode_t cpuDecode, // Decoded region
  output logic cpuDecodeValid, // Decode valid
  output logic [1:0] matchHit, // Address match hits
  output msd_ctrl_t sfrCtrl // Register values
);

  // Derived region bounds
  localparam logic [19:0] ROM_LO =
    20'(32'(ROM_TOP) - ROM_KBYTES * 1024);
  localparam logic [19:0] RAM_HI =
    20'(32'(RAM_LO) + RAM_BYTES - 1);

  // Refuse sizes the map cannot hold
  if (!(ROM_KBYTES inside {8, 16, 24, 32}))
  begin : g_bad_rom
    $error("ROM size must be 8, 16, 24 or 32 Kbytes");
  end
  if (!(RAM_BYTES inside {512, 1024, 1536}))
  begin : g_bad_ram
    $error("RAM size must be 512, 1024 or 1536 bytes");
  end

  // Populated register bytes
  function automatic logic isMapped(input logic [5:0] idx);
    case (idx)
      OFF_PROC_MODE_0, OFF_PROC_MODE_1,
      OFF_CLK_CTRL_0, OFF_CLK_CTRL_1,
      OFF_WRITE_PROTECT, OFF_OSC_STOP,
      OFF_WDOG_REFRESH, OFF_WDOG_BEGIN,
      OFF_WDOG_CONTROL, OFF_MATCH_ENABLE,
      OFF_COUNT_SRC, OFF_HS_OSC_0,
      OFF_HS_OSC_1, OFF_HS_OSC_2,
      OFF_PRESCALE_FLAG, OFF_HS_OSC_4,
      OFF_HS_OSC_6, OFF_HS_OSC_7: return 1'b1;
      OFF_MATCH_0, OFF_MATCH_0 + 6'h1,
      OFF_MATCH_0 + 6'h2: return 1'b1;
      OFF_MATCH_1, OFF_MATCH_1 + 6'h1,
      OFF_MATCH_1 + 6'h2: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Reset value of each register byte
  function automatic logic [7:0] rstValue(input logic [5:0] idx);
    case (idx)
      OFF_CLK_CTRL_0: return RST_CLK_CTRL_0;
      OFF_CLK_CTRL_1: return RST_CLK_CTRL_1;
      OFF_OSC_STOP: return RST_OSC_STOP;
      // watchdog control, bit 5 taken low
      OFF_WDOG_CONTROL: return RST_WDOG_CONTROL;
      OFF_HS_OSC_1: return TRIM_1;
      OFF_HS_OSC_4: return TRIM_4;
      OFF_HS_OSC_6: return TRIM_6;
      OFF_HS_OSC_7: return TRIM_7;
      default: return RST_ZERO;
    endcase
  endfunction

  // Region decode of one core address
  function automatic msd_decode_t decodeAddr(
    input logic [ADDR_W-1:0] a
  );
    msd_decode_t d;
    d.inVector = (a >= VEC_LO) && (a <= VEC_HI);
    d.sfrMapped = (a < 20'(SFR_N)) && isMapped(a[5:0]);
    if (a <= SFR_HI)
      d.region = RGN_SFR;
    else if ((a >= RAM_LO) && (a <= RAM_HI))
      d.region = RGN_RAM;
    else if ((a >= ROM_LO) && (a <= ROM_HI))
      d.region = RGN_ROM;
    else
      d.region = RGN_RSVD;
    return d;
  endfunction

  // Register storage and bus state
  logic [SFR_N-1:0][7:0] sfrMem; // Register bytes
  logic waitReg; // Stall flag
  logic waitNext; // Next stall flag
  logic [31:0] rdataReg; // Read data
  logic [31:0] rdataNext; // Next read data
  msd_decode_t decodeReg; // Decode result
  logic decValidReg; // Decode valid
  logic [1:0] matchReg; // Match hits
  logic [1:0] matchNext; // Next match hits

  // Bus decode
  wire logic busReq = read | write; // Request present
  wire logic [5:0] busIdx = address[7:2]; // Register index
  wire logic busInRange =
    address[BUS_AW-1:2] < 10'(SFR_N); // Inside bank
  wire logic busStatus =
    busInRange && (busIdx == OFF_STATUS); // Status word
  wire logic busMapped =
    busInRange && isMapped(busIdx); // Populated byte
  wire logic wrFire =
    write && !waitReg && busMapped && byteenable[0];

  // Address match compare words
  wire logic [23:0] match0 = {sfrMem[OFF_MATCH_0 + 6'h2],
    sfrMem[OFF_MATCH_0 + 6'h1], sfrMem[OFF_MATCH_0]};
  wire logic [23:0] match1 = {sfrMem[OFF_MATCH_1 + 6'h2],
    sfrMem[OFF_MATCH_1 + 6'h1], sfrMem[OFF_MATCH_1]};
  wire logic [7:0] matchEn = sfrMem[OFF_MATCH_ENABLE];

  // Own status word: last decode and match state
  wire logic [7:0] statusByte = {3'h0, matchReg,
    decodeReg.inVector, 2'(decodeReg.region)};

  // Read selection
  // unpopulated space reads zero
  wire logic [31:0] readValue =
    busStatus ? {24'h0, statusByte} :
    busMapped ? {24'h0, sfrMem[busIdx]} : 32'h0;

  // One wait cycle, then completion, then idle
  assign waitNext = !(busReq && waitReg);
  // Capture read data in the wait cycle
  assign rdataNext = (read && waitReg) ? readValue : rdataReg;

  assign matchNext[0] = cpuValid && matchEn[MATCH_EN_0] &&
    (cpuAddr == match0[ADDR_W-1:0]);
  assign matchNext[1] = cpuValid && matchEn[MATCH_EN_1] &&
    (cpuAddr == match1[ADDR_W-1:0]);

  // Register bytes, reset to documented values
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < SFR_N; i++)
        sfrMem[i] <= rstValue(6'(i));
    end
    else if (wrFire)
    begin
      sfrMem[busIdx] <= writedata[7:0];
    end
  end

  // Bus handshake state
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      waitReg <= 1'b1;
      rdataReg <= 32'h0;
    end
    else
    begin
      waitReg <= waitNext;
      rdataReg <= rdataNext;
    end
  end

  // Core address decode pipeline
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      decodeReg <= '{RGN_RSVD, 1'b0, 1'b0};
      decValidReg <= 1'b0;
      matchReg <= 2'h0;
    end
    else
    begin
      decodeReg <= decodeAddr(cpuAddr);
      decValidReg <= cpuValid;
      matchReg <= matchNext;
    end
  end

  // Outputs straight from flops
  assign waitrequest = waitReg;
  assign readdata = rdataReg;
  assign cpuDecode = decodeReg;
  assign cpuDecodeValid = decValidReg;
  assign matchHit = matchReg;
  assign sfrCtrl = '{
    procMode0: sfrMem[OFF_PROC_MODE_0],
    procMode1: sfrMem[OFF_PROC_MODE_1],
    clkCtrl0: sfrMem[OFF_CLK_CTRL_0],
    clkCtrl1: sfrMem[OFF_CLK_CTRL_1],
    writeProtect: sfrMem[OFF_WRITE_PROTECT],
    oscStopDetect: sfrMem[OFF_OSC_STOP],
    wdogControl: sfrMem[OFF_WDOG_CONTROL],
    countSrcProtect: sfrMem[OFF_COUNT_SRC],
    prescalerReset: sfrMem[OFF_PRESCALE_FLAG],
    hsOsc0: sfrMem[OFF_HS_OSC_0],
    hsOsc1: sfrMem[OFF_HS_OSC_1],
    hsOsc2: sfrMem[OFF_HS_OSC_2],
    hsOsc4: sfrMem[OFF_HS_OSC_4],
    hsOsc6: sfrMem[OFF_HS_OSC_6],
    hsOsc7: sfrMem[OFF_HS_OSC_7]};

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  // First cycle after reset release
  logic firstReg;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      firstReg <= 1'b1;
    else
      firstReg <= 1'b0;
  end

  // Address falls in some region
  wire logic inAnyRegion = (cpuAddr <= SFR_HI) ||
    ((cpuAddr >= RAM_LO) && (cpuAddr <= RAM_HI)) ||
    ((cpuAddr >= ROM_LO) && (cpuAddr <= ROM_HI));

  property p_one_region;
    !firstReg |=> ((cpuDecode.region == RGN_RSVD) == $past(!inAnyRegion));
  endproperty
  a_one_region: assert property (p_one_region)
    else $error("reserved decode mismatch");

  property p_rom_region;
    !firstReg && (cpuAddr >= ROM_LO) && (cpuAddr <= ROM_HI)
      |=> cpuDecode.region == RGN_ROM;
  endproperty
  a_rom_region: assert property (p_rom_region)
    else $error("ROM address not decoded as ROM");

  property p_ram_region;
    !firstReg && (cpuAddr >= RAM_LO) && (cpuAddr <= RAM_HI)
      |=> cpuDecode.region == RGN_RAM;
  endproperty
  a_ram_region: assert property (p_ram_region)
    else $error("RAM address not decoded as RAM");

  // vector flag only inside top ROM
  property p_vector;
    !firstReg |=> cpuDecode.inVector ==
      ($past(cpuAddr) >= VEC_LO && $past(cpuAddr) <= VEC_HI);
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector flag wrong");

  property p_sfr_region;
    !firstReg && cpuAddr <= SFR_HI |=> cpuDecode.region == RGN_SFR;
  endproperty
  a_sfr_region: assert property (p_sfr_region)
    else $error("register address not decoded");

  property p_mode_reset;
    firstReg |-> sfrCtrl.procMode0 == RST_ZERO &&
      sfrCtrl.procMode1 == RST_ZERO;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("processor mode reset wrong");

  property p_clk_reset;
    firstReg |-> sfrCtrl.clkCtrl0 == RST_CLK_CTRL_0 &&
      sfrCtrl.clkCtrl1 == RST_CLK_CTRL_1;
  endproperty
  a_clk_reset: assert property (p_clk_reset)
    else $error("clock control reset wrong");

  property p_osc_wdog_reset;
    firstReg |-> sfrCtrl.oscStopDetect == RST_OSC_STOP &&
      (sfrCtrl.wdogControl & WDOG_DEFINED) == RST_WDOG_CONTROL;
  endproperty
  a_osc_wdog_reset: assert property (p_osc_wdog_reset)
    else $error("stop detect or watchdog reset wrong");

  property p_zero_reset;
    firstReg |-> match0 == 24'h0 && match1 == 24'h0 &&
      matchEn == RST_ZERO && sfrCtrl.countSrcProtect == RST_ZERO &&
      sfrCtrl.prescalerReset == RST_ZERO;
  endproperty
  a_zero_reset: assert property (p_zero_reset)
    else $error("cleared register not zero");

  property p_trim_reset;
    firstReg |-> sfrCtrl.hsOsc1 == TRIM_1 && sfrCtrl.hsOsc4 == TRIM_4 &&
      sfrCtrl.hsOsc6 == TRIM_6 && sfrCtrl.hsOsc7 == TRIM_7;
  endproperty
  a_trim_reset: assert property (p_trim_reset)
    else $error("trim reset wrong");

  // enabled match 0 raises hit 0 next cycle
  property p_match_hit;
    !firstReg && cpuValid && matchEn[MATCH_EN_0] &&
      cpuAddr == match0[ADDR_W-1:0] |=> matchHit[0];
  endproperty
  a_match_hit: assert property (p_match_hit)
    else $error("address match missed");

  // Completing accesses on the bus
  sequence s_wr_unmapped;
    write && !waitrequest && !busMapped;
  endsequence
  sequence s_rd_unmapped;
    read && !waitrequest && !busMapped && !busStatus;
  endsequence

  property p_ignore_write;
    s_wr_unmapped |=> $stable(sfrMem);
  endproperty
  a_ignore_write: assert property (p_ignore_write)
    else $error("unmapped write changed a register");

  property p_unmapped_read;
    s_rd_unmapped |-> readdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not zero");

  // Request answered after exactly one wait cycle
  sequence s_new_req;
    (read || write) && waitrequest;
  endsequence
  property p_bus_answer;
    s_new_req |=> !waitrequest ##1 waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer timing wrong");

  // Mapped write lands at completion
  property p_write_lands;
    write && !waitrequest && busMapped && byteenable[0]
      |=> sfrMem[$past(busIdx)] == $past(writedata[7:0]);
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("register write lost");

endmodule // msd_sfr_decoder

`default_nettype wire

// >>> test/msd_cpu_model.sv
/*
  Core side model that presents one address per cycle to the decoder.
  Assumes the bench hands it addresses on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none

module msd_cpu_model
  import msd_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic rstn, // Async reset, low
  input wire logic [ADDR_W-1:0] reqAddr, // Address to issue
  input wire logic reqValid, // Issue request
  output logic [ADDR_W-1:0] cpuAddr, // Core address bus
  output logic cpuValid // Core address valid
);

  // Issue address; an idle bus toggles so stale values never pass
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cpuAddr <= '0;
      cpuValid <= 1'b0;
    end
    else
    begin
      cpuAddr <= reqValid ? reqAddr : ~cpuAddr;
      cpuValid <= reqValid;
    end
  end

endmodule // msd_cpu_model

`default_nettype wire

// >>> test/msd_sfr_decoder_test.sv
/*
  Self-checking bench for the decoder and register bank.
  Assumes the bench is the only register bus master.
*/
`timescale 1ns/100ps
`default_nettype none

module msd_sfr_decoder_test;
  import msd_pkg::*;

  logic clock, rstn, read, write; // Clock, reset, strobes
  logic [BUS_AW-1:0] address; // Bus address
  logic [31:0] writedata, readdata; // Bus data
  logic [3:0] byteenable; // Lane enables
  logic waitrequest, cpuValid, reqValid, cpuDecodeValid; // Flags
  logic [ADDR_W-1:0] cpuAddr, reqAddr; // Core addresses
  msd_decode_t cpuDecode; // Decode result
  logic [1:0] matchHit; // Match hits
  msd_ctrl_t sfrCtrl; // Register outputs
  int err_total, checks_done; // Counters
  int cycles = 0; // Timeout counter
  logic [7:0] rd; // Read data
  // Mapped index, reset value, defined-bit mask
  logic [23:0] regTab [24] = '{24'h0400ff, 24'h0500ff, 24'h0668ff,
    24'h0720ff, 24'h0a00ff, 24'h0c04ff, 24'h0d0000, 24'h0e0000,
    24'h0f1fdf, 24'h1000ff, 24'h1100ff, 24'h1200ff, 24'h1300ff,
    24'h1400ff, 24'h1500ff, 24'h1600ff, 24'h1c00ff, 24'h2300ff,
    24'h2431ff, 24'h2500ff, 24'h2800ff, 24'h2934ff, 24'h2b36ff,
    24'h2c37ff};
  // Core address, region, vector, mapped
  logic [23:0] decTab [15] = '{24'h000000, 24'h000041, 24'h002ff0,
    24'h00300c, 24'h003ffc, 24'h004004, 24'h009ff4, 24'h00a00c,
    24'h07fffc, 24'h080008, 24'h0ffdb8, 24'h0ffdca, 24'h0ffffa,
    24'h10000c, 24'hfffffc};
  // Match registers 0 and 1, both enabled
  logic [15:0] matchTab [7] = '{16'h1045, 16'h1123, 16'h1201, 16'h1456,
    16'h1534, 16'h1602, 16'h1303};

  msd_sfr_decoder #(.TRIM_1(8'h31), .TRIM_4(8'h34), .TRIM_6(8'h36),
    .TRIM_7(8'h37)) DUT (.clock(clock), .rstn(rstn), .address(address),
    .read(read), .write(write), .writedata(writedata),
    .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .cpuAddr(cpuAddr), .cpuValid(cpuValid),
    .cpuDecode(cpuDecode), .cpuDecodeValid(cpuDecodeValid),
    .matchHit(matchHit), .sfrCtrl(sfrCtrl));

  msd_cpu_model cpu (.clock(clock), .rstn(rstn), .reqAddr(reqAddr),
    .reqValid(reqValid), .cpuAddr(cpuAddr), .cpuValid(cpuValid));

  // Clock generator
  initial
  begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Counts and verdict, then stop
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Byte comparison
  task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: byte %h not %h", $time, got, exp);
    end
  endtask

  // Wide comparison
  task automatic chkWide(input logic [119:0] got, input logic [119:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %h not %h", $time, got, exp);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
    input logic [7:0] wd, input logic be, output logic [7:0] q);
    @(posedge clock);
    address <= {2'h0, idx, 2'h0};
    read <= !wr;
    write <= wr;
    writedata <= {24'h0, wd};
    byteenable <= {3'h0, be};
    do
      @(posedge clock);
    while (waitrequest !== 1'b0);
    q = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  // Present one core address and check the decode at the third edge
  task automatic dec(input logic [19:0] a, input logic [3:0] e,
    input logic [1:0] hit);
    @(posedge clock);
    reqAddr <= a;
    reqValid <= 1'b1;
    repeat (3) @(posedge clock);
    chkWide(120'({cpuDecodeValid, matchHit, cpuDecode}),
      120'({1'b1, hit, e}));
    reqValid <= 1'b0;
  endtask

  // Timeout guard
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_total++;
      results();
    end
  end

  // Main sequence
  initial
  begin
    rstn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = '0;
    writedata = '0;
    byteenable = 4'h1;
    reqAddr = '0;
    reqValid = 1'b0;
    err_total = 0;
    checks_done = 0;
    repeat (2) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    chkWide(sfrCtrl & ~(120'h1 << 69), {8'h00, 8'h00, 8'h68, 8'h20, 8'h00,
      8'h04, 8'h1f, 8'h00, 8'h00, 8'h00, 8'h31, 8'h00, 8'h34, 8'h36,
      8'h37});
    for (int i = 0; i < 24; i++)
    begin
      bus(1'b0, regTab[i][23:16], 8'h00, 1'b1, rd);
      chkByte(rd & regTab[i][7:0], regTab[i][15:8] & regTab[i][7:0]);
    end
    $display("test reset values done");
    for (int i = 0; i < 15; i++)
      dec(decTab[i][23:4], decTab[i][3:0], 2'b00);
    $display("test decode map done");
    for (int i = 0; i < 24; i++)
      bus(1'b1, regTab[i][23:16], regTab[i][23:16] ^ 8'h5a, 1'b1, rd);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'({8'h08, 8'h2f, 8'h3f, 8'h40} >> (8 * i)), 8'hff, 1'b1, rd);
      bus(1'b0, 8'({8'h08, 8'h2f, 8'h3f, 8'h40} >> (8 * i)), 8'h00, 1'b1, rd);
      chkByte(rd, 8'h00);
    end
    bus(1'b1, 8'h04, 8'hee, 1'b0, rd);
    for (int i = 0; i < 24; i++)
    begin
      bus(1'b0, regTab[i][23:16], 8'h00, 1'b1, rd);
      chkByte(rd, regTab[i][23:16] ^ 8'h5a);
    end
    chkWide(sfrCtrl, {8'h5e, 8'h5f, 8'h5c, 8'h5d, 8'h50, 8'h56, 8'h55,
      8'h46, 8'h72, 8'h79, 8'h7e, 8'h7f, 8'h73, 8'h71, 8'h76});
    $display("test write and read back done");
    for (int i = 0; i < 7; i++)
      bus(1'b1, matchTab[i][15:8], matchTab[i][7:0], 1'b1, rd);
    dec(20'h12345, 4'hc, 2'b01);
    dec(20'h23456, 4'hc, 2'b10);
    // Hold a matching address and read the status word
    @(posedge clock);
    reqAddr <= 20'h12345;
    reqValid <= 1'b1;
    repeat (2) @(posedge clock);
    bus(1'b0, 8'h2e, 8'h00, 1'b1, rd);
    chkByte(rd, 8'h0b);
    reqValid <= 1'b0;
    bus(1'b1, 8'h13, 8'h02, 1'b1, rd);
    dec(20'h12345, 4'hc, 2'b00);
    $display("test address match done");
    results();
  end

endmodule // msd_sfr_decoder_test

`default_nettype wire
